//--- logic/ifeb_pkg.sv
// Purpose: Shared constants for the interrupt flag and permit bank
// Assumes: 16-bit registers on word-aligned 32-bit bus slots
// Notes:   Masks mark the implemented bits; all other bits read zero
`default_nettype none
package ifeb_pkg;

    // Byte addresses of the registers
    localparam logic [7:0] A_PEND2 = 8'h00;
    localparam logic [7:0] A_PEND3 = 8'h04;
    localparam logic [7:0] A_PEND4 = 8'h08;
    localparam logic [7:0] A_PERM0 = 8'h0c;
    localparam logic [7:0] A_PERM1 = 8'h10;
    localparam logic [7:0] A_PRIO  = 8'h14;
    localparam logic [7:0] A_EVST  = 8'h18;
    localparam logic [7:0] A_EVCLR = 8'h1c;
    localparam logic [7:0] A_EVEN  = 8'h20;

    // Implemented bits per register
    localparam logic [15:0] MASK_PEND2 = 16'h0007;
    localparam logic [15:0] MASK_PEND3 = 16'h39ff;
    localparam logic [15:0] MASK_PEND4 = 16'h00f6;
    localparam logic [15:0] MASK_PERM0 = 16'h7fff;
    localparam logic [15:0] MASK_PERM1 = 16'hfffb;
    localparam logic [15:0] RST_REG16  = 16'h0000;

    // Timer 1 priority field and the permit bit it qualifies
    localparam int unsigned PRIO_LSB   = 12;
    localparam logic [2:0]  PRIO_RST   = 3'h4;
    localparam logic [2:0]  PRIO_OFF   = 3'h0;
    localparam int unsigned TMR1_BIT   = 3;

    // Event status bits: a new request raised in group 2, 3 or 4
    localparam int unsigned EVT_W      = 3;
    localparam logic [2:0]  EVT_RST    = 3'h0;

    // Merge write data into a 16-bit register under the byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] cur,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
        merge16 = cur;
        if (sel[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

endpackage
`default_nettype wire

//--- logic/ifeb_flag_bank.sv
// Purpose: One sticky flag register of sixteen request bits
// Assumes: Events are one-clock pulses or levels from same-clock logic
// Notes:   A set in the same cycle as a software clear wins
`default_nettype none
`timescale 1ns/1ns
module ifeb_flag_bank #(
    parameter logic [15:0] MASK = 16'hffff
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] evt_in,
    input  wire logic        wr_in,
    input  wire logic [15:0] wr_val_in,
    output logic      [15:0] flag_out,
    output logic             raised_out
);
    typedef struct packed {
        logic [15:0] flag;
    } ifeb_bank_t;

    ifeb_bank_t st_ff;
    ifeb_bank_t nxt_st;

    // Software value first, then events OR in so none is lost
    always_comb begin
        nxt_st = st_ff;
        if (wr_in) begin
            nxt_st.flag = wr_val_in;
        end
        nxt_st.flag = (nxt_st.flag | evt_in) & MASK;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_ff <= '{flag: ifeb_pkg::RST_REG16};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flag_out   = st_ff.flag;
    assign raised_out = |(evt_in & MASK);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_evt_sets;
        (evt_in & MASK) != 16'h0000 |=> (flag_out & $past(evt_in & MASK)) == $past(evt_in & MASK);
    endproperty
    a_evt_sets: assert property (p_evt_sets) else $error("event did not set flag");

    property p_sticky;
        !wr_in |=> ($past(flag_out) & ~flag_out) == 16'h0000;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag fell without a write");

    property p_unimpl_zero;
        (flag_out & ~MASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented flag bit set");
endmodule
`default_nettype wire

//--- logic/ifeb_pick.sv
// Purpose: Finds the lowest-numbered active request
// Assumes: Purely combinational; the caller registers the result
// Notes:   Fixed natural order among requests of equal standing
`default_nettype none
`timescale 1ns/1ns
module ifeb_pick #(
    parameter int unsigned N  = 80,
    parameter int unsigned IW = 7
) (
    input  wire logic [N-1:0]  req_in,
    output logic      [IW-1:0] idx_out,
    output logic               valid_out
);
    // Scan from the top so the lowest set bit is kept last
    function automatic logic [IW-1:0] first_set(input logic [N-1:0] v);
        first_set = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = IW'(i);
            end
        end
    endfunction

    assign idx_out   = first_set(req_in);
    assign valid_out = |req_in;
endmodule
`default_nettype wire

//--- logic/ifeb_bank.sv
// Purpose: Interrupt flag and permit register bank on classic Wishbone
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   Flag groups 0/1 and permit groups 2..4 live outside this bank
`default_nettype none
`timescale 1ns/1ns

// Contract
// - A flag reads 1 once its source raised a request, else 0.
// - A permit bit of 1 passes its source's request; 0 blocks it.
// - Unimplemented bits read zero and ignore writes.
// - All implemented flag and permit bits clear at reset.
// - Software may read and write every implemented flag and permit bit.
// - Pending group 2 bits 2..0: CAN A rx ready, SPI B event, error.
// - Group 3: 13 DMA5, 12/11 codec event/error, 8 CAN B event.
// - Group 3 bits 7..0: CAN B rx, pins 4/3, timers 9/8, I2C B, timer 7.
// - Group 4: bits 7..4 CAN tx B/A, DMA 7/6; bits 2/1 UART errors.
// - Permit 0 bits 14..8: DMA1, conv A, UART A tx/rx, SPI A, timer 3.
// - Permit 0 bits 7..0: timer 2, cmp 2, cap 2, DMA0, timer 1, cmp/cap 1, pin 0.
// - Permit 1 bits 15..8: UART B tx/rx, pin 2, timers 5/4, cmp 4/3, DMA2.
// - Permit 1 bits 7..3 cap 8/7, conv B, pin 1, change; 1/0 I2C A.
// - Three-bit priority: 111 is level 7 highest, 000 disables the source; the code only mutes timer 1 at 000, and the picker ignores levels.
module ifeb_bank (
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    input  wire logic [15:0] EVT_GRP2_IN,
    input  wire logic [15:0] EVT_GRP3_IN,
    input  wire logic [15:0] EVT_GRP4_IN,
    input  wire logic [15:0] FLAG_GRP0_IN,
    input  wire logic [15:0] FLAG_GRP1_IN,
    input  wire logic [15:0] PERMIT_GRP2_IN,
    input  wire logic [15:0] PERMIT_GRP3_IN,
    input  wire logic [15:0] PERMIT_GRP4_IN,
    output logic      [15:0] PEND_GRP2_OUT,
    output logic      [15:0] PEND_GRP3_OUT,
    output logic      [15:0] PEND_GRP4_OUT,
    output logic      [15:0] REQ_GRP0_OUT,
    output logic      [15:0] REQ_GRP1_OUT,
    output logic      [15:0] REQ_GRP2_OUT,
    output logic      [15:0] REQ_GRP3_OUT,
    output logic      [15:0] REQ_GRP4_OUT,
    output logic      [6:0]  TOP_SRC_OUT,
    output logic             TOP_VALID_OUT,
    output logic             IRQ_OUT
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic [15:0] perm0;
        logic [15:0] perm1;
        logic [2:0]  prio;
        logic [2:0]  evst;
        logic [2:0]  even;
        logic        irq;
        logic [15:0] req0;
        logic [15:0] req1;
        logic [15:0] req2;
        logic [15:0] req3;
        logic [15:0] req4;
        logic [6:0]  top;
        logic        topv;
    } ifeb_state_t;

    ifeb_state_t st_ff;
    ifeb_state_t nxt_st;

    logic        hit;
    logic        commit;
    logic        wr_p2;
    logic        wr_p3;
    logic        wr_p4;
    logic [15:0] pend2;
    logic [15:0] pend3;
    logic [15:0] pend4;
    logic [2:0]  raised;
    logic [2:0]  clr;
    logic [79:0] req_all;
    logic [15:0] mute_t1;
    logic [6:0]  pick_idx;
    logic        pick_valid;

    // Level 0 switches a source off; any other code lets it through
    function automatic logic prio_live(input logic [2:0] code);
        prio_live = (code != ifeb_pkg::PRIO_OFF);
    endfunction

    // A write lands only on the edge where the master sees ack high
    assign hit    = WB_CYC_IN && WB_STB_IN;
    assign commit = hit && WB_WE_IN && st_ff.ack;
    assign wr_p2  = commit && (WB_ADR_IN == ifeb_pkg::A_PEND2);
    assign wr_p3  = commit && (WB_ADR_IN == ifeb_pkg::A_PEND3);
    assign wr_p4  = commit && (WB_ADR_IN == ifeb_pkg::A_PEND4);

    // Write-one-to-clear for event status, lane 0 only
    assign clr = (commit && (WB_ADR_IN == ifeb_pkg::A_EVCLR) && WB_SEL_IN[0]) ?
                 WB_DAT_IN[2:0] : 3'h0;

    // Group 2 keeps only its low three request bits
    ifeb_flag_bank #(
        .MASK (ifeb_pkg::MASK_PEND2)
    ) u_pend2 (
        .clk_in     (CLK_IN),
        .rst_in     (RST_IN),
        .evt_in     (EVT_GRP2_IN),
        .wr_in      (wr_p2),
        .wr_val_in  (ifeb_pkg::merge16(pend2, WB_DAT_IN, WB_SEL_IN)),
        .flag_out   (pend2),
        .raised_out (raised[0])
    );

    // Group 3 has gaps at bits 15..14 and 10..9
    ifeb_flag_bank #(
        .MASK (ifeb_pkg::MASK_PEND3)
    ) u_pend3 (
        .clk_in     (CLK_IN),
        .rst_in     (RST_IN),
        .evt_in     (EVT_GRP3_IN),
        .wr_in      (wr_p3),
        .wr_val_in  (ifeb_pkg::merge16(pend3, WB_DAT_IN, WB_SEL_IN)),
        .flag_out   (pend3),
        .raised_out (raised[1])
    );

    // Group 4 uses bits 7..4, 2 and 1 only
    ifeb_flag_bank #(
        .MASK (ifeb_pkg::MASK_PEND4)
    ) u_pend4 (
        .clk_in     (CLK_IN),
        .rst_in     (RST_IN),
        .evt_in     (EVT_GRP4_IN),
        .wr_in      (wr_p4),
        .wr_val_in  (ifeb_pkg::merge16(pend4, WB_DAT_IN, WB_SEL_IN)),
        .flag_out   (pend4),
        .raised_out (raised[2])
    );

    // A zero priority code mutes timer 1 even when permitted
    assign mute_t1 = prio_live(st_ff.prio) ? 16'h0000
                                           : (16'h0001 << ifeb_pkg::TMR1_BIT);

    // Gate requests outside the state process: the picker reads them, and
    // taking them from nxt_st would close a loop through that process
    assign req_all = {pend4 & PERMIT_GRP4_IN,
                      pend3 & PERMIT_GRP3_IN,
                      pend2 & PERMIT_GRP2_IN,
                      FLAG_GRP1_IN & st_ff.perm1,
                      FLAG_GRP0_IN & st_ff.perm0 & ~mute_t1};

    ifeb_pick #(
        .N  (80),
        .IW (7)
    ) u_pick (
        .req_in    (req_all),
        .idx_out   (pick_idx),
        .valid_out (pick_valid)
    );

    // Bus access, permit and priority registers, gated request registers, status
    always_comb begin
        nxt_st = st_ff;

        // Ack one cycle after the request, then drop for one cycle
        nxt_st.ack = hit && !st_ff.ack;
        nxt_st.dat = 32'h0000_0000;
        if (hit && !st_ff.ack && !WB_WE_IN) begin
            if (WB_ADR_IN == ifeb_pkg::A_PEND2) begin
                nxt_st.dat[15:0] = pend2;
            end else if (WB_ADR_IN == ifeb_pkg::A_PEND3) begin
                nxt_st.dat[15:0] = pend3;
            end else if (WB_ADR_IN == ifeb_pkg::A_PEND4) begin
                nxt_st.dat[15:0] = pend4;
            end else if (WB_ADR_IN == ifeb_pkg::A_PERM0) begin
                nxt_st.dat[15:0] = st_ff.perm0;
            end else if (WB_ADR_IN == ifeb_pkg::A_PERM1) begin
                nxt_st.dat[15:0] = st_ff.perm1;
            end else if (WB_ADR_IN == ifeb_pkg::A_PRIO) begin
                nxt_st.dat[ifeb_pkg::PRIO_LSB +: 3] = st_ff.prio;
            end else if (WB_ADR_IN == ifeb_pkg::A_EVST) begin
                nxt_st.dat[2:0] = st_ff.evst;
            end else if (WB_ADR_IN == ifeb_pkg::A_EVEN) begin
                nxt_st.dat[2:0] = st_ff.even;
            end
        end

        // Register writes; masks keep gaps at zero
        if (commit) begin
            if (WB_ADR_IN == ifeb_pkg::A_PERM0) begin
                nxt_st.perm0 = ifeb_pkg::merge16(st_ff.perm0, WB_DAT_IN, WB_SEL_IN)
                               & ifeb_pkg::MASK_PERM0;
            end else if (WB_ADR_IN == ifeb_pkg::A_PERM1) begin
                nxt_st.perm1 = ifeb_pkg::merge16(st_ff.perm1, WB_DAT_IN, WB_SEL_IN)
                               & ifeb_pkg::MASK_PERM1;
            end else if (WB_ADR_IN == ifeb_pkg::A_PRIO) begin
                if (WB_SEL_IN[1]) begin
                    nxt_st.prio = WB_DAT_IN[ifeb_pkg::PRIO_LSB +: 3];
                end
            end else if (WB_ADR_IN == ifeb_pkg::A_EVEN) begin
                if (WB_SEL_IN[0]) begin
                    nxt_st.even = WB_DAT_IN[2:0];
                end
            end
        end

        // Gated requests register beside the index picked from them
        {nxt_st.req4, nxt_st.req3, nxt_st.req2, nxt_st.req1, nxt_st.req0} = req_all;

        nxt_st.top  = pick_idx;
        nxt_st.topv = pick_valid;

        // Set beats clear so an event in the clearing cycle survives
        nxt_st.evst = (st_ff.evst & ~clr) | raised;
        nxt_st.irq  = |(nxt_st.evst & nxt_st.even);
    end

    // Single register stage for all bank state outside the three flag banks
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            st_ff <= '{ack: 1'b0, dat: 32'h0000_0000,
                       perm0: ifeb_pkg::RST_REG16,
                       perm1: ifeb_pkg::RST_REG16,
                       prio: ifeb_pkg::PRIO_RST,
                       evst: ifeb_pkg::EVT_RST,
                       even: ifeb_pkg::EVT_RST,
                       irq: 1'b0,
                       req0: 16'h0000, req1: 16'h0000, req2: 16'h0000,
                       req3: 16'h0000, req4: 16'h0000,
                       top: 7'h00, topv: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register or the flag banks
    assign WB_ACK_OUT    = st_ff.ack;
    assign WB_DAT_OUT    = st_ff.dat;
    assign PEND_GRP2_OUT = pend2;
    assign PEND_GRP3_OUT = pend3;
    assign PEND_GRP4_OUT = pend4;
    assign REQ_GRP0_OUT  = st_ff.req0;
    assign REQ_GRP1_OUT  = st_ff.req1;
    assign REQ_GRP2_OUT  = st_ff.req2;
    assign REQ_GRP3_OUT  = st_ff.req3;
    assign REQ_GRP4_OUT  = st_ff.req4;
    assign TOP_SRC_OUT   = st_ff.top;
    assign TOP_VALID_OUT = st_ff.topv;
    assign IRQ_OUT       = st_ff.irq;

    // Checks on the bus handshake and the request paths
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_ack_once;
        hit && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

    property p_req_gate;
        1'b1 |=> REQ_GRP1_OUT == ($past(FLAG_GRP1_IN) & $past(st_ff.perm1));
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("group 1 request not gated");

    property p_req3_both;
        1'b1 |=> REQ_GRP3_OUT == ($past(PEND_GRP3_OUT) & $past(PERMIT_GRP3_IN));
    endproperty
    a_req3_both: assert property (p_req3_both) else $error("group 3 request wrong");

    property p_gap_read;
        WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == ifeb_pkg::A_PERM1
            |-> WB_DAT_OUT[2] == 1'b0 && WB_DAT_OUT[31:16] == 16'h0000;
    endproperty
    a_gap_read: assert property (p_gap_read) else $error("gap bit read nonzero");

    property p_reset_clear;
        $past(RST_IN) |-> st_ff.perm0 == 16'h0000 && st_ff.perm1 == 16'h0000
                          && PEND_GRP3_OUT == 16'h0000 && !IRQ_OUT;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("bits not clear after reset");

    property p_perm_write;
        commit && WB_ADR_IN == ifeb_pkg::A_PERM0 && WB_SEL_IN[1:0] == 2'b11
            |=> st_ff.perm0 == ($past(WB_DAT_IN[15:0]) & ifeb_pkg::MASK_PERM0);
    endproperty
    a_perm_write: assert property (p_perm_write) else $error("permit write lost");

    property p_prio_off;
        st_ff.prio == ifeb_pkg::PRIO_OFF |=> !REQ_GRP0_OUT[ifeb_pkg::TMR1_BIT];
    endproperty
    a_prio_off: assert property (p_prio_off) else $error("muted source forwarded");

    property p_set_wins;
        raised[1] && clr[1] |=> st_ff.evst[1] ##1 st_ff.evst[1] || $past(clr[1]);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost under clear");

    property p_irq_level;
        ##1 IRQ_OUT == |(st_ff.evst & st_ff.even);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    // Permit gaps must stay zero whatever software writes
    property p_perm_gaps;
        (st_ff.perm0 & ~ifeb_pkg::MASK_PERM0) == 16'h0000
            && (st_ff.perm1 & ~ifeb_pkg::MASK_PERM1) == 16'h0000;
    endproperty
    a_perm_gaps: assert property (p_perm_gaps) else $error("permit gap bit set");

    property p_rd_high_zero;
        WB_ACK_OUT |-> WB_DAT_OUT[31:16] == 16'h0000;
    endproperty
    a_rd_high_zero: assert property (p_rd_high_zero) else $error("upper half nonzero");

    property p_evst_set;
        raised[1] |=> st_ff.evst[1];
    endproperty
    a_evst_set: assert property (p_evst_set) else $error("group 3 event not noted");

    c_read: cover property (hit && !WB_WE_IN ##1 WB_ACK_OUT);
    c_irq: cover property (!IRQ_OUT ##1 IRQ_OUT);
    c_top: cover property (TOP_VALID_OUT && TOP_SRC_OUT > 7'd31);
    c_clr_race: cover property (raised[1] && clr[1]);
endmodule
`default_nettype wire

//--- testbench/ifeb_periph_model.sv
// Purpose: Peripheral event sources that face the flag bank
// Assumes: Same clock as the bank; the bench says when each event starts
// Notes:   Lines fall to zero between events, as a real source does
`default_nettype none
`timescale 1ns/1ns
module ifeb_periph_model (
    input  wire logic        clk_in,
    input  wire logic        fire_in,
    input  wire logic [3:0]  hold_in,
    input  wire logic [47:0] pat_in,
    output logic      [15:0] evt2_out,
    output logic      [15:0] evt3_out,
    output logic      [15:0] evt4_out
);
    logic [3:0] left;

    // A slow source holds its line for extra cycles; it is still one request
    always @(posedge clk_in) begin
        if (fire_in) begin
            {evt4_out, evt3_out, evt2_out} <= pat_in;
            left <= hold_in;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end else begin
            {evt4_out, evt3_out, evt2_out} <= 48'h0;
        end
    end
endmodule
`default_nettype wire

//--- testbench/ifeb_bank_tb_top.sv
// Purpose: Self-checking bench for the flag and permit bank
// Assumes: Classic Wishbone master, one 25 MHz clock
// Notes:   Event status is compared only after reset and in the interrupt tests
`default_nettype none
`timescale 1ns/1ns
module ifeb_bank_tb_top;
    logic        clk, rst, cyc, stb, we, ack, topv, irq, fire;
    logic [7:0]  adr;
    logic [3:0]  sel, hold;
    logic [31:0] wdat, rdat;
    logic [47:0] pat;
    logic [6:0]  top;
    logic [15:0] ev [5];
    logic [15:0] fl [2];
    logic [15:0] pi [5];
    logic [15:0] pd [5];
    logic [15:0] rq [5];
    int          num_errors, check_count, m_prio, m_evst, m_even;
    int          m_pd [5];
    int          m_perm [2];
    int          pmask [5] = '{0, 0, 'h0007, 'h39ff, 'h00f6};

    ifeb_bank u_ifeb_bank (.CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .EVT_GRP2_IN(ev[2]), .EVT_GRP3_IN(ev[3]), .EVT_GRP4_IN(ev[4]),
        .FLAG_GRP0_IN(fl[0]), .FLAG_GRP1_IN(fl[1]), .PERMIT_GRP2_IN(pi[2]),
        .PERMIT_GRP3_IN(pi[3]), .PERMIT_GRP4_IN(pi[4]), .PEND_GRP2_OUT(pd[2]),
        .PEND_GRP3_OUT(pd[3]), .PEND_GRP4_OUT(pd[4]), .REQ_GRP0_OUT(rq[0]),
        .REQ_GRP1_OUT(rq[1]), .REQ_GRP2_OUT(rq[2]), .REQ_GRP3_OUT(rq[3]),
        .REQ_GRP4_OUT(rq[4]), .TOP_SRC_OUT(top), .TOP_VALID_OUT(topv), .IRQ_OUT(irq));

    ifeb_periph_model u_ifeb_periph_model (.clk_in(clk), .fire_in(fire), .hold_in(hold),
        .pat_in(pat), .evt2_out(ev[2]), .evt3_out(ev[3]), .evt4_out(ev[4]));

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic int mrg(input int cur, input logic [31:0] d, input logic [3:0] s);
        mrg = cur;
        if (s[0]) mrg[7:0] = d[7:0];
        if (s[1]) mrg[15:8] = d[15:8];
    endfunction

    function automatic logic [31:0] mread(input logic [7:0] a);
        case (a)
            8'h00, 8'h04, 8'h08: mread = m_pd[a[3:2] + 2];
            8'h0c: mread = m_perm[0];
            8'h10: mread = m_perm[1];
            8'h14: mread = m_prio << 12;
            8'h18: mread = m_evst;
            8'h20: mread = m_even;
            default: mread = 0;
        endcase
    endfunction

    // One classic cycle; request held until ack is sampled high, data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, s, d, q);
        case (a)
            8'h00, 8'h04, 8'h08: m_pd[a[3:2] + 2] = mrg(m_pd[a[3:2] + 2], d, s) & pmask[a[3:2] + 2];
            8'h0c: m_perm[0] = mrg(m_perm[0], d, s) & 'h7fff;
            8'h10: m_perm[1] = mrg(m_perm[1], d, s) & 'hfffb;
            8'h14: if (s[1]) m_prio = d[14:12];
            8'h1c: if (s[0]) m_evst = m_evst & ~int'(d[2:0]);
            8'h20: if (s[0]) m_even = d[2:0];
            default: ;
        endcase
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] q;
        wb(1'b0, a, 4'hf, 32'h0, q);
        chk("read data", q, mread(a));
    endtask

    // Launch an event pattern and let it settle into flags and requests
    task automatic ev_fire(input logic [47:0] p, input logic [3:0] h);
        fire <= 1'b1; pat <= p; hold <= h;
        @(posedge clk);
        fire <= 1'b0;
        for (int g = 2; g < 5; g++) begin
            m_pd[g] = m_pd[g] | (int'(p[(g-2)*16 +: 16]) & pmask[g]);
            if ((int'(p[(g-2)*16 +: 16]) & pmask[g]) != 0) m_evst = m_evst | (1 << (g - 2));
        end
        repeat (int'(h) + 4) @(posedge clk);
    endtask

    task automatic chk_outs();
        int r [5];
        int t;
        t = -1;
        r[0] = fl[0] & m_perm[0] & ((m_prio == 0) ? 'hfff7 : 'hffff);
        r[1] = fl[1] & m_perm[1];
        for (int g = 2; g < 5; g++) begin
            r[g] = m_pd[g] & pi[g];
            chk("pending flags", pd[g], m_pd[g]);
        end
        for (int g = 0; g < 5; g++) begin
            chk("forwarded requests", rq[g], r[g]);
            for (int b = 0; b < 16; b++) if (t < 0 && r[g][b]) t = g * 16 + b;
        end
        chk("top valid", topv, t >= 0);
        if (t >= 0) chk("top source", top, t);
    endtask

    // Watchdog sized well above the fewer than a thousand cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        logic [47:0] p;
        cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0; fire = 0; hold = 0; pat = 0;
        fl = '{16'h0, 16'h0}; pi = '{5{16'h0}}; rst = 1'b1;
        m_pd = '{5{0}}; m_perm = '{0, 0}; m_prio = 4; m_evst = 0; m_even = 0;
        void'($urandom(32'h0e1f));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a <= 'h24; a += 4) rd(8'(a));
        // Every place written with ones then zeros; unmapped and read-only stay put
        for (int a = 0; a <= 'h24; a += 4) begin
            wr(8'(a), 4'h3, 32'hffffffff);
            if (a != 'h18) rd(8'(a));
            wr(8'(a), 4'h3, 32'h0);
            if (a != 'h18) rd(8'(a));
        end
        wr(8'h10, 4'h1, 32'h0000ffff);
        rd(8'h10);
        wr(8'h10, 4'h2, 32'h0000ffff);
        rd(8'h10);
        // Random sources, permits and software clears
        for (int i = 0; i < 30; i++) begin
            fl[0] <= 16'($urandom); fl[1] <= 16'($urandom);
            for (int g = 2; g < 5; g++) pi[g] <= 16'($urandom);
            wr(8'h0c, 4'h3, $urandom);
            wr(8'h10, 4'h3, $urandom);
            wr(8'h14, 4'h2, $urandom);
            p = {$urandom, $urandom};
            ev_fire(p, 4'($urandom % 3));
            chk_outs();
            wr(8'(($urandom % 3) * 4), 4'h3, $urandom);
            repeat (3) @(posedge clk);
            chk_outs();
        end
        // Priority code zero blocks timer 1, level seven passes it
        fl[0] <= 16'h0008;
        wr(8'h0c, 4'h3, 32'h8);
        wr(8'h14, 4'h2, 32'h0);
        repeat (3) @(posedge clk);
        chk_outs();
        wr(8'h14, 4'h2, 32'h7000);
        repeat (3) @(posedge clk);
        chk_outs();
        // Interrupt raised, masked, unmasked and cleared
        for (int g = 0; g < 3; g++) wr(8'(g * 4), 4'h3, 32'h0);
        wr(8'h1c, 4'h1, 32'h7);
        wr(8'h20, 4'h1, 32'h2);
        ev_fire(48'h0001_0000_0000, 4'h0);
        rd(8'h18);
        rd(8'h08);
        ev_fire(48'h0000_2000_0000, 4'h0);
        rd(8'h18);
        chk("irq", irq, 1'b1);
        wr(8'h20, 4'h1, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b0);
        wr(8'h20, 4'h1, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b1);
        wr(8'h1c, 4'h1, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b0);
        // Clear lands while a long event still stands, so the set must win
        fork
            ev_fire(48'h0000_2000_0000, 4'hf);
            wr(8'h1c, 4'h1, 32'h2);
        join
        m_evst = m_evst | 2;
        rd(8'h18);
        chk("irq", irq, 1'b1);
        rd(8'h04);
        complete_run();
    end
endmodule
`default_nettype wire
